/* File: logic/irc_defines.svh */
`ifndef IRC_DEFINES_SVH
`define IRC_DEFINES_SVH

// oscillator timing
`define IRC_OSC_PER_MC 12
`define IRC_PHASE_W 4
`define IRC_PHASE_LAST 4'hb
`define IRC_SAMPLE_PHASE 4'h9
`define IRC_CALL_PERIODS 24
`define IRC_RST_ENTRY_PERIODS 24
`define IRC_INIT_PERIODS 12
`define IRC_CNT_W 5

// sources in polling order
`define IRC_NSRC 5
`define IRC_SRC_EXT0 3'h0
`define IRC_SRC_TMR0 3'h1
`define IRC_SRC_EXT1 3'h2
`define IRC_SRC_TMR1 3'h3
`define IRC_SRC_SER 3'h4

// register byte addresses
`define IRC_ADDR_W 5
`define IRC_REG_ENABLE 5'h00
`define IRC_REG_PRIORITY 5'h04
`define IRC_REG_FLAGS 5'h08
`define IRC_REG_CTRL 5'h0c
`define IRC_REG_STATUS 5'h10

// field positions and reset values
`define IRC_GATE_BIT 7
`define IRC_ENABLE_RST 8'h00
`define IRC_PRIORITY_RST 5'h00
`define IRC_CTRL_RST 2'h0
`define IRC_START_ADDR 16'h0000
`define IRC_PORT_PRESET_MASK 5'h0f

`endif

/* File: logic/irc_pkg.sv */
package irc_pkg;

  typedef enum logic [1:0] {
    rst_run = 2'b00,
    rst_entry = 2'b01,
    rst_dormant = 2'b10,
    rst_init = 2'b11
  } rst_state_e;

  typedef struct packed {
    logic active;
    logic high_level;
    logic [2:0] source;
  } call_s;

  typedef struct packed {
    logic last_cycle;
    logic blocking;
    logic return_from_interrupt_instr;
  } core_evt_s;

endpackage

/* File: logic/interrupt_and_reset_control.sv */
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`include "irc_defines.svh"
// What this block does
// (RULE1) two in-service flops, low and high level
// (RULE2) return instruction clears serviced level's flop
// (RULE3) latch requests in 10th period of cycles
// (RULE4) request needs enable and priority bit qualification
// (RULE5) acknowledge sets in-service, issues call, pushes counter
// (RULE6) hardware clears edge and timer flags on vector
// (RULE7) software clears serial and level external flags; code clears a level external flag when its pin samples high
// (RULE8) late requests wait one more instruction
// (RULE9) hardware call lasts two machine cycles
// (RULE10) after return or enable access, wait one instruction
// (RULE11) single interrupt latency between three and eight cycles
// (RULE12) equal or higher level in service blocks
// (RULE13) reset pin held low two machine cycles
// (RULE14) stop executing 24 periods after reset low
// (RULE15) twelve-period init then fetch from 0000h
// (RULE16) reset presets port latches except port four
// (RULE17) keep strobe undriven during and after reset
// (RULE18) global gate zero blocks every acknowledge
// (RULE19) high level preempts low, never same
// (RULE20) fixed polling order inside one level
// (RULE21) reset clears both in-service flops
module interrupt_and_reset_control (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [`IRC_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic reset_pin_n_in,
  input wire logic ext_irq_line0_in,
  input wire logic ext_irq_line1_in,
  input wire logic timer0_overflow_in,
  input wire logic timer1_overflow_in,
  input wire logic serial_event_in,
  input irc_pkg::core_evt_s core_evt_in,
  output irc_pkg::call_s call_out,
  output logic [1:0] in_service_out,
  output logic run_out,
  output logic fetch_start_out,
  output logic [15:0] fetch_addr_out,
  output logic [4:0] port_preset_out
);

  localparam int NSRC = `IRC_NSRC;

  // first pending source of a vector in polling order
  function automatic logic [2:0] first_src(input logic [NSRC-1:0] req);
    logic [2:0] idx;
    idx = `IRC_SRC_SER;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  logic [1:0] ext_meta_r;
  logic [1:0] ext_sync_r;
  logic rst_meta_r;
  logic rst_sync_r;
  irc_pkg::rst_state_e rst_state_r;
  logic [`IRC_CNT_W-1:0] rst_cnt_r;
  logic [`IRC_PHASE_W-1:0] phase_r;
  logic [7:0] enable_r;
  logic [NSRC-1:0] priority_r;
  logic [NSRC-1:0] flags_r;
  logic [NSRC-1:0] flags_nxt;
  logic [1:0] edge_mode_r;
  logic [1:0] ext_prev_r;
  logic [NSRC-1:0] sample_r;
  logic [NSRC-1:0] poll_r;
  logic [1:0] in_service_r;
  irc_pkg::call_s call_r;
  logic [`IRC_CNT_W-1:0] call_cnt_r;
  logic bus_ack_r;
  logic [31:0] rdata_r;
  logic fetch_start_r;

  logic running;
  logic dormant;
  logic mc_end;
  logic sample_now;
  logic call_done;
  logic [NSRC-1:0] qual;
  logic [NSRC-1:0] hi_req;
  logic [NSRC-1:0] lo_req;
  logic take_hi;
  logic take_lo;
  logic ack;
  logic bus_req;
  logic bus_wr;
  logic [NSRC-1:0] flag_set;
  logic [NSRC-1:0] flag_clr;

  assign running = (rst_state_r == irc_pkg::rst_run) || (rst_state_r == irc_pkg::rst_entry);
  assign dormant = (rst_state_r == irc_pkg::rst_dormant);
  assign mc_end = running && (phase_r == `IRC_PHASE_LAST);
  assign sample_now = running && (phase_r == `IRC_SAMPLE_PHASE);
  assign call_done = call_r.active && (call_cnt_r == `IRC_CNT_W'(`IRC_CALL_PERIODS - 1));

  // pin synchronisers
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ext_meta_r <= 2'h3;
      ext_sync_r <= 2'h3;
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      ext_meta_r <= {ext_irq_line1_in, ext_irq_line0_in};
      ext_sync_r <= ext_meta_r;
      rst_meta_r <= reset_pin_n_in;
      rst_sync_r <= rst_meta_r;
    end
  end

  // reset pin sequencing
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_state_r <= irc_pkg::rst_dormant;
      rst_cnt_r <= '0;
      fetch_start_r <= 1'b0;
    end else begin
      fetch_start_r <= 1'b0;
      unique case (rst_state_r)
        irc_pkg::rst_run: begin
          rst_cnt_r <= '0;
          if (!rst_sync_r) begin
            rst_state_r <= irc_pkg::rst_entry;
          end
        end
        irc_pkg::rst_entry: begin
          if (rst_sync_r) begin
            rst_state_r <= irc_pkg::rst_run;
          end else if (rst_cnt_r == `IRC_CNT_W'(`IRC_RST_ENTRY_PERIODS - 1)) begin
            rst_state_r <= irc_pkg::rst_dormant; // see (RULE14) see (RULE13)
            rst_cnt_r <= '0;
          end else begin
            rst_cnt_r <= rst_cnt_r + 1'b1;
          end
        end
        irc_pkg::rst_dormant: begin
          rst_cnt_r <= '0;
          if (rst_sync_r) begin
            rst_state_r <= irc_pkg::rst_init;
          end
        end
        irc_pkg::rst_init: begin
          if (!rst_sync_r) begin
            rst_state_r <= irc_pkg::rst_dormant;
            rst_cnt_r <= '0;
          end else if (rst_cnt_r == `IRC_CNT_W'(`IRC_INIT_PERIODS - 1)) begin
            rst_state_r <= irc_pkg::rst_run; // see (RULE15)
            fetch_start_r <= 1'b1;
          end else begin
            rst_cnt_r <= rst_cnt_r + 1'b1;
          end
        end
      endcase
    end
  end

  // oscillator period within the machine cycle
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_r <= '0;
    end else if (!running || phase_r == `IRC_PHASE_LAST) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + 1'b1;
    end
  end

  // register bus
  assign bus_req = avs_read_in || avs_write_in;
  assign bus_wr = avs_write_in && bus_ack_r;
  assign avs_waitrequest_out = bus_req && !bus_ack_r;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      bus_ack_r <= bus_req && !bus_ack_r;
      rdata_r <= '0;
      unique case (avs_address_in)
        `IRC_REG_ENABLE: rdata_r[7:0] <= enable_r;
        `IRC_REG_PRIORITY: rdata_r[NSRC-1:0] <= priority_r;
        `IRC_REG_FLAGS: rdata_r[NSRC-1:0] <= flags_r;
        `IRC_REG_CTRL: rdata_r[1:0] <= edge_mode_r;
        `IRC_REG_STATUS: rdata_r[3:0] <= {running, call_r.active, in_service_r};
        default: rdata_r <= '0;
      endcase
    end
  end
  assign avs_readdata_out = rdata_r;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      enable_r <= `IRC_ENABLE_RST;
      priority_r <= `IRC_PRIORITY_RST;
      edge_mode_r <= `IRC_CTRL_RST;
    end else if (dormant) begin
      enable_r <= `IRC_ENABLE_RST;
      priority_r <= `IRC_PRIORITY_RST;
      edge_mode_r <= `IRC_CTRL_RST;
    end else if (bus_wr) begin
      if (avs_address_in == `IRC_REG_ENABLE) begin
        enable_r <= avs_writedata_in[7:0];
      end
      if (avs_address_in == `IRC_REG_PRIORITY) begin
        priority_r <= avs_writedata_in[NSRC-1:0];
      end
      if (avs_address_in == `IRC_REG_CTRL) begin
        edge_mode_r <= avs_writedata_in[1:0];
      end
    end
  end

  // request flags: hardware set wins over any clear
  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    for (int e = 0; e < 2; e++) begin
      if (sample_now) begin
        if (edge_mode_r[e]) begin
          flag_set[2*e] = ext_prev_r[e] && !ext_sync_r[e];
        end else begin
          flag_set[2*e] = !ext_sync_r[e];
          flag_clr[2*e] = ext_sync_r[e];
        end
      end
    end
    flag_set[`IRC_SRC_TMR0] = timer0_overflow_in;
    flag_set[`IRC_SRC_TMR1] = timer1_overflow_in;
    flag_set[`IRC_SRC_SER] = serial_event_in;
    if (call_done) begin
      unique case (call_r.source)
        `IRC_SRC_EXT0: flag_clr[`IRC_SRC_EXT0] = edge_mode_r[0]; // see (RULE6) see (RULE7)
        `IRC_SRC_EXT1: flag_clr[`IRC_SRC_EXT1] = edge_mode_r[1]; // see (RULE6) see (RULE7)
        `IRC_SRC_TMR0: flag_clr[`IRC_SRC_TMR0] = 1'b1; // see (RULE6)
        `IRC_SRC_TMR1: flag_clr[`IRC_SRC_TMR1] = 1'b1; // see (RULE6)
        default: flag_clr = flag_clr;
      endcase
    end
    flags_nxt = (bus_wr && avs_address_in == `IRC_REG_FLAGS) ?
                avs_writedata_in[NSRC-1:0] : flags_r;
    flags_nxt = (flags_nxt & ~flag_clr) | flag_set;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flags_r <= '0;
      ext_prev_r <= 2'h3;
    end else if (dormant) begin
      flags_r <= '0;
      ext_prev_r <= 2'h3;
    end else begin
      flags_r <= flags_nxt;
      if (sample_now) begin
        ext_prev_r <= ext_sync_r;
      end
    end
  end

  // sample in the 10th period, poll one machine cycle later
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sample_r <= '0;
      poll_r <= '0;
    end else begin
      if (sample_now) begin
        sample_r <= flags_r; // see (RULE3)
      end
      if (mc_end) begin
        poll_r <= sample_r; // see (RULE8)
      end
    end
  end

  // qualification and arbitration
  assign qual = poll_r & enable_r[NSRC-1:0] & {NSRC{enable_r[`IRC_GATE_BIT]}}; // see (RULE4) see (RULE18)
  assign hi_req = qual & priority_r;
  assign lo_req = qual & ~priority_r;
  assign take_hi = (|hi_req) && !in_service_r[1]; // see (RULE19) see (RULE12)
  assign take_lo = (|lo_req) && (in_service_r == 2'h0); // see (RULE12)
  assign ack = mc_end && core_evt_in.last_cycle && !core_evt_in.blocking &&
               !call_r.active && (take_hi || take_lo); // see (RULE10) see (RULE11)

  // hardware call: core pushes the counter only, status word untouched
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      call_r <= '0;
      call_cnt_r <= '0;
    end else if (!running) begin
      call_r <= '0;
      call_cnt_r <= '0;
    end else if (ack) begin
      call_r.active <= 1'b1; // see (RULE5)
      call_r.high_level <= take_hi;
      call_r.source <= take_hi ? first_src(hi_req) : first_src(lo_req); // see (RULE20)
      call_cnt_r <= '0;
    end else if (call_done) begin
      call_r.active <= 1'b0; // see (RULE9)
    end else if (call_r.active) begin
      call_cnt_r <= call_cnt_r + 1'b1;
    end
  end
  assign call_out = call_r;

  // in-service flops
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      in_service_r <= 2'h0;
    end else if (dormant) begin
      in_service_r <= 2'h0; // see (RULE21)
    end else if (call_done) begin
      in_service_r[call_r.high_level] <= 1'b1; // see (RULE1) see (RULE5)
    end else if (core_evt_in.return_from_interrupt_instr && running) begin
      if (in_service_r[1]) begin
        in_service_r[1] <= 1'b0; // see (RULE2)
      end else begin
        in_service_r[0] <= 1'b0; // see (RULE2)
      end
    end
  end
  assign in_service_out = in_service_r;

  // core and port side
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      run_out <= 1'b0;
      port_preset_out <= '0;
    end else begin
      run_out <= running && !(rst_state_r == irc_pkg::rst_entry && rst_cnt_r ==
                 `IRC_CNT_W'(`IRC_RST_ENTRY_PERIODS - 1)); // see (RULE14)
      port_preset_out <= dormant ? `IRC_PORT_PRESET_MASK : 5'h00; // see (RULE16)
    end
  end
  assign fetch_start_out = fetch_start_r;
  assign fetch_addr_out = `IRC_START_ADDR; // see (RULE15)

endmodule

/* File: tb/irc_properties.sv */
`timescale 1ns/1ns
module irc_properties (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic reset_pin_n_in,
  input irc_pkg::core_evt_s core_evt_in,
  input irc_pkg::call_s call_out,
  input wire logic [1:0] in_service_out,
  input wire logic run_out,
  input wire logic fetch_start_out,
  input wire logic [15:0] fetch_addr_out,
  input wire logic [4:0] port_preset_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);
  AST_CALL_LEN: assert property (
    $rose(call_out.active) |-> ##23 call_out.active ##1 !call_out.active)
    else $error("call not 24 clocks");
  AST_LOW_CALL: assert property (
    $rose(call_out.active) && !call_out.high_level |-> in_service_out == 2'b00)
    else $error("low call while in service");
  AST_HI_BLOCK: assert property (
    $rose(call_out.active) |-> !in_service_out[1])
    else $error("call during high service");
  AST_ISR_HI: assert property (
    $fell(call_out.active) && $past(call_out.high_level) |-> ##[0:1] in_service_out[1])
    else $error("high in-service not set");
  AST_RETURN_FROM_INTERRUPT_INSTR: assert property (
    core_evt_in.return_from_interrupt_instr |=> in_service_out ==
      ($past(in_service_out[1]) ? {1'b0, $past(in_service_out[0])} : 2'b00))
    else $error("return cleared wrong level");
  AST_RUN_STOP: assert property (
    $fell(run_out) |-> !$past(reset_pin_n_in, 20))
    else $error("stopped too early");
  AST_RUN_HOLD: assert property (
    $fell(reset_pin_n_in) && run_out |-> run_out[*8])
    else $error("run dropped at once");
  AST_FETCH: assert property (
    $rose(fetch_start_out) |-> fetch_addr_out == 16'h0000 && in_service_out == 2'b00
      && $past(reset_pin_n_in, 12) ##1 run_out && !fetch_start_out)
    else $error("bad start sequence");
  AST_PORT: assert property (
    port_preset_out != 5'h00 |-> port_preset_out == 5'h0f && !run_out)
    else $error("bad port preset");
endmodule
bind interrupt_and_reset_control irc_properties u_props (.core_clk_in(core_clk_in),
  .resetn_in(resetn_in), .reset_pin_n_in(reset_pin_n_in), .core_evt_in(core_evt_in),
  .call_out(call_out), .in_service_out(in_service_out), .run_out(run_out),
  .fetch_start_out(fetch_start_out), .fetch_addr_out(fetch_addr_out),
  .port_preset_out(port_preset_out));

/* File: tb/core_model.sv */
`timescale 1ns/1ns
module core_model (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic run_in,
  input wire logic [2:0] len_in,
  input wire logic blocking_in,
  input wire logic return_from_interrupt_instr_req_in,
  output irc_pkg::core_evt_s core_evt_out
);
  logic [3:0] phase_r;
  logic [2:0] mc_r;
  logic [2:0] len_r;
  logic end_w;
  // instruction of 1 to 4 machine cycles ends at phase 11 of its last one
  assign end_w = (phase_r == 4'hb) && (mc_r == len_r - 3'h1);
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_r <= 4'h0;
      mc_r <= 3'h0;
      len_r <= 3'h1;
    end else if (!run_in) begin
      // run_in lags the start of execution by one clock, so resume at period one
      phase_r <= 4'h1;
      mc_r <= 3'h0;
      len_r <= 3'h1;
    end else begin
      phase_r <= (phase_r == 4'hb) ? 4'h0 : phase_r + 4'h1;
      if (phase_r == 4'hb) begin
        mc_r <= end_w ? 3'h0 : mc_r + 3'h1;
        if (end_w) begin
          len_r <= len_in;
        end
      end
    end
  end
  // return and enable or priority accesses hold off the acknowledge
  assign core_evt_out = '{last_cycle: end_w, blocking: end_w && (blocking_in || return_from_interrupt_instr_req_in),
    return_from_interrupt_instr: end_w && return_from_interrupt_instr_req_in};
endmodule

/* File: tb/interrupt_and_reset_control_tb.sv */
`timescale 1ns/1ns
module interrupt_and_reset_control_tb;
  logic clk = 0, rstn = 0, rd = 0, wr = 0, pin_n = 1, t0 = 0, t1 = 0, ser = 0, blk = 0, rq = 0;
  logic e0 = 1, e1 = 1;
  logic [4:0] adr = 5'h00, pp, m;
  logic [31:0] wd = 32'h0, q, rdat;
  logic [2:0] len = 3'h1, src;
  logic wt, run, fst;
  logic [1:0] isr;
  logic [15:0] fa;
  irc_pkg::core_evt_s evt;
  irc_pkg::call_s call;
  int fail_count = 0, checks_done = 0, cyc = 0, lat = 0;
  always #25 clk = ~clk;
  interrupt_and_reset_control DUT (.core_clk_in(clk), .resetn_in(rstn), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wt), .reset_pin_n_in(pin_n), .ext_irq_line0_in(e0),
    .ext_irq_line1_in(e1), .timer0_overflow_in(t0), .timer1_overflow_in(t1),
    .serial_event_in(ser), .core_evt_in(evt), .call_out(call), .in_service_out(isr),
    .run_out(run), .fetch_start_out(fst), .fetch_addr_out(fa), .port_preset_out(pp));
  core_model partner (.core_clk_in(clk), .resetn_in(rstn), .run_in(run), .len_in(len),
    .blocking_in(blk), .return_from_interrupt_instr_req_in(rq), .core_evt_out(evt));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d checks %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wait_act(input logic lv);
    int n;
    n = 0;
    while (call.active !== lv && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk(n < 300, 1);
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk);
      chk(call.active, 1'b0);
    end
  endtask
  task automatic pulse(input logic [4:0] s);
    @(posedge clk);
    t0 <= s[1];
    t1 <= s[3];
    ser <= s[4];
    @(posedge clk);
    t0 <= 1'b0;
    t1 <= 1'b0;
    ser <= 1'b0;
  endtask
  task automatic ret();
    int n;
    n = 0;
    // let a cleared flag reach the poll latch before service ends
    repeat (24) @(posedge clk);
    rq <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (evt.return_from_interrupt_instr !== 1'b1 && n < 200);
    chk(n < 200, 1);
    rq <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  function automatic logic [2:0] first_src(input logic [4:0] s);
    for (int i = 4; i >= 0; i--) begin
      if (s[i]) begin
        first_src = 3'(i);
      end
    end
  endfunction
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    void'($urandom(90));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 100 && run !== 1'b1; i++) @(posedge clk);
    chk({isr, pp}, 0);
    bus(0, 5'h00, 0);
    chk(q, 0);
    bus(0, 5'h14, 0);
    chk(q, 0);
    bus(1, 5'h0c, 32'h3);
    repeat (6) begin
      m = 5'($urandom_range(1, 31));
      len <= 3'($urandom_range(1, 4));
      src = first_src(m);
      bus(1, 5'h00, 32'h1f);
      bus(1, 5'h08, {27'h0, m & 5'h05});
      pulse(m);
      quiet(150);
      blk <= 1'b1;
      bus(1, 5'h00, 32'h9f);
      quiet(100);
      blk <= 1'b0;
      wait_act(1);
      chk({call.high_level, call.source}, {1'b0, src});
      wait_act(0);
      @(posedge clk);
      chk(isr, 2'b01);
      bus(0, 5'h08, 0);
      chk(q[4:0], src == 3'h4 ? m : m & ~(5'h01 << src));
      bus(1, 5'h08, 0);
      ret();
      chk(isr, 2'b00);
    end
    bus(1, 5'h04, 32'h10);
    pulse(5'h02);
    lat = cyc;
    wait_act(1);
    wait_act(0);
    chk(cyc - lat > 37 && cyc - lat < 97, 1);
    pulse(5'h18);
    wait_act(1);
    chk({call.high_level, call.source}, 4'hc);
    wait_act(0);
    @(posedge clk);
    chk(isr, 2'b11);
    bus(1, 5'h08, 32'h08);
    ret();
    chk(isr, 2'b01);
    quiet(100);
    ret();
    wait_act(1);
    chk(call.source, 3'h3);
    wait_act(0);
    bus(1, 5'h08, 0);
    ret();
    bus(1, 5'h0c, 32'h0);
    e0 <= 1'b0;
    wait_act(1);
    chk(call.source, 3'h0);
    wait_act(0);
    bus(0, 5'h08, 0);
    chk(q[0], 1'b1);
    e0 <= 1'b1;
    repeat (30) @(posedge clk);
    bus(0, 5'h08, 0);
    chk(q[0], 1'b0);
    ret();
    bus(1, 5'h0c, 32'h3);
    e1 <= 1'b0;
    wait_act(1);
    chk(call.source, 3'h2);
    wait_act(0);
    bus(0, 5'h08, 0);
    chk(q[2], 1'b0);
    e1 <= 1'b1;
    ret();
    // nothing here drives the address strobe, so it is never pulled low
    pin_n <= 1'b0; // held far longer than two machine cycles
    repeat (40) @(posedge clk);
    chk({run, pp}, 6'h0f);
    pin_n <= 1'b1;
    for (int i = 0; i < 100 && fst !== 1'b1; i++) @(posedge clk);
    chk({fst, isr, fa}, 19'h40000);
    for (int i = 0; i < 10 && run !== 1'b1; i++) @(posedge clk);
    bus(0, 5'h04, 0);
    chk(q, 0);
    bus(0, 5'h10, 0);
    chk(q, 32'h8);
    close_out();
  end
endmodule
